/* core/esx_addr_map.sv */
`timescale 1ns/1ps
// ============================================================
// operand address mapping for standard byte/bit instructions
module esx_addr_map #(
    parameter int DADDR_W = 12
) (
    input wire logic ext_en,
    input wire logic acc_sel,
    input wire logic [7:0] file_lit,
    input wire logic [3:0] bank_sel,
    input wire logic [DADDR_W-1:0] ssp,
    output logic [DADDR_W-1:0] addr,
    output logic indexed
);

    // the banked address is a bank nibble on top of the literal byte
    if (DADDR_W != esx_pkg::BANK_W + esx_pkg::BYTE_W) begin : g_bad_width
        $error("esx_addr_map: address width must equal bank plus literal width");
    end

    // short literals in the access bank become stack offsets when extended
    assign indexed = ext_en && !acc_sel && (file_lit <= esx_pkg::ILO_LIMIT);

    // with a zero pointer the indexed sum equals the low access bank address
    always_comb begin
        if (indexed) begin
            addr = ssp + DADDR_W'(file_lit);
        end else if (acc_sel) begin
            addr = {bank_sel, file_lit};
        end else if (file_lit <= esx_pkg::ILO_LIMIT) begin
            addr = {esx_pkg::ACC_LO_BANK, file_lit};
        end else begin
            addr = {esx_pkg::ACC_HI_BANK, file_lit};
        end
    end

endmodule // esx_addr_map

/* core/esx_core.sv */
`timescale 1ns/1ps
// Function
// - indexed-to-file source address is stack pointer plus 7-bit offset.
// - indexed-to-file destination is the 12-bit literal of word two.
// - indexed-to-file is 1110 1011 0 plus offset, then 1111 plus address.
// - indexed-to-indexed source and destination are stack pointer plus offsets.
// - indexed-to-indexed is 1110 1011 1 offset, then 1111 xxxx x offset.
// - source on an indirect register reads as zero.
// - indexed destination on an indirect register makes the move a no-op.
// - push literal writes byte at stack pointer, then decrements it; one cycle.
// - subtract 6-bit literal from pointer 0..2 in one cycle.
// - subtract is recognised by 1110 1001, select, literal in one word.
// - select 11 subtracts from stack pointer then returns from top of stack.
// - subtract-and-return takes two cycles, second one idle.
// - enabling the extension also enables indexed literal offset addressing.
// - disabled: access bit 0 uses access bank, 1 uses bank select.
// - enabled, access bit 0, operand up to 5Fh is stack pointer offset.
// - zero stack pointer gives the legacy access bank addresses.
// - destination bit keeps choosing working register or memory.
// - one configuration bit gates both extended opcodes and indexed addressing.
// - call via working register pushes pc+2 and loads the latched target.
module esx_core #(
    parameter logic [11:0] IND_LO = 12'hf00,
    parameter logic [11:0] IND_HI = 12'hf00
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic extended_set_enable,
    input wire logic instr_valid,
    input wire logic [esx_pkg::WORD_W-1:0] instr_word,
    input wire logic [esx_pkg::PC_W-1:0] pc_now,
    input wire logic [esx_pkg::BYTE_W-1:0] working_register,
    input wire logic [esx_pkg::BYTE_W-1:0] pc_latch_high,
    input wire logic [esx_pkg::PCU_W-1:0] pc_latch_upper,
    input wire logic [esx_pkg::BANK_W-1:0] bank_select_register,
    input wire logic [esx_pkg::PC_W-1:0] return_stack_top,
    input wire logic [esx_pkg::BYTE_W-1:0] mem_rd_data,
    input wire logic ptr_wr_en,
    input wire logic [esx_pkg::SEL_W-1:0] ptr_wr_sel,
    input wire logic [esx_pkg::DADDR_W-1:0] ptr_wr_data,
    output esx_pkg::esx_mem_req_t mem_req,
    output esx_pkg::esx_flow_req_t flow_req,
    output logic [esx_pkg::NPTR-1:0][esx_pkg::DADDR_W-1:0] ptr_out,
    output logic [esx_pkg::DADDR_W-1:0] std_operand_addr,
    output logic std_dest_to_w,
    output logic std_indexed,
    output logic busy
);

    // ============================================================
    // elaboration checks
    if (IND_LO > IND_HI) begin : g_bad_ind_range
        $error("esx_core: indirect register range is reversed");
    end

    // ============================================================
    // state
    esx_pkg::esx_state_t st_q, st_d;
    esx_pkg::esx_mem_req_t mem_q, mem_d;
    esx_pkg::esx_flow_req_t flow_q, flow_d;
    logic [esx_pkg::NPTR-1:0][esx_pkg::DADDR_W-1:0] ptr_q, ptr_d;
    logic mv_indexed_q, mv_indexed_d;
    logic src_zero_q, src_zero_d;
    logic [esx_pkg::DADDR_W-1:0] std_addr_q, std_addr_d;
    logic std_dest_w_q, std_dest_w_d;
    logic std_idx_q, std_idx_d;
    logic busy_q, busy_d;

    // ============================================================
    // decode
    logic [esx_pkg::DADDR_W-1:0] ssp;
    logic [esx_pkg::DADDR_W-1:0] map_addr;
    logic map_indexed;
    logic dec_move, dec_push, dec_sub, dec_call_via_working_reg, dec_second;
    logic [esx_pkg::DADDR_W-1:0] ofs_ext, subk_ext, src_addr, dst_idx_addr;
    logic [esx_pkg::SEL_W-1:0] sub_sel;

    assign ssp = ptr_q[esx_pkg::SSP_IDX];

    // every extended opcode is qualified by the configuration bit
    assign dec_move = extended_set_enable
        && instr_word[esx_pkg::WORD_W-1:esx_pkg::OPC_LSB] == esx_pkg::OPC_MOVE_IDX;
    assign dec_push = extended_set_enable
        && instr_word[esx_pkg::WORD_W-1:esx_pkg::OPC_LSB] == esx_pkg::OPC_PUSH_LIT;
    assign dec_sub = extended_set_enable
        && instr_word[esx_pkg::WORD_W-1:esx_pkg::OPC_LSB] == esx_pkg::OPC_SUB_PTR;
    assign dec_call_via_working_reg = extended_set_enable && instr_word == esx_pkg::OPC_CALL_W;
    assign dec_second = instr_word[esx_pkg::WORD_W-1:esx_pkg::SECOND_LSB] == esx_pkg::OPC_SECOND;

    // offsets zero-extended, so sums wrap in the 12-bit space
    assign ofs_ext = esx_pkg::DADDR_W'(instr_word[esx_pkg::OFS_W-1:0]);
    assign subk_ext = esx_pkg::DADDR_W'(instr_word[esx_pkg::SUBK_W-1:0]);
    assign sub_sel = instr_word[esx_pkg::SEL_LSB +: esx_pkg::SEL_W];
    assign src_addr = ssp + ofs_ext;
    assign dst_idx_addr = ssp + ofs_ext;

    function automatic logic is_indirect(input logic [esx_pkg::DADDR_W-1:0] a);
        is_indirect = (a >= IND_LO) && (a <= IND_HI);
    endfunction

    // the same bit that enables the opcodes switches the operand mapping
    esx_addr_map #(
        .DADDR_W(esx_pkg::DADDR_W)
    ) u_map (
        .ext_en(extended_set_enable),
        .acc_sel(instr_word[esx_pkg::ACC_BIT]),
        .file_lit(instr_word[esx_pkg::BYTE_W-1:0]),
        .bank_sel(bank_select_register),
        .ssp(ssp),
        .addr(map_addr),
        .indexed(map_indexed)
    );

    // ============================================================
    // next-state logic
    // requests are one-cycle strobes; addresses and data hold between them
    always_comb begin
        st_d = st_q;
        mem_d = mem_q;
        mem_d.rd_en = 1'b0;
        mem_d.wr_en = 1'b0;
        flow_d = flow_q;
        flow_d.push = 1'b0;
        flow_d.pop = 1'b0;
        flow_d.pc_load = 1'b0;
        ptr_d = ptr_q;
        mv_indexed_d = mv_indexed_q;
        src_zero_d = src_zero_q;
        std_addr_d = std_addr_q;
        std_dest_w_d = std_dest_w_q;
        std_idx_d = std_idx_q;
        // core writes to a pointer; a push or subtract on that same pointer in the same cycle overrides it
        if (ptr_wr_en && (ptr_wr_sel != esx_pkg::SEL_RETURN)) begin
            ptr_d[ptr_wr_sel] = ptr_wr_data;
        end
        case (st_q)
            esx_pkg::ST_DECODE: begin
                if (instr_valid) begin
                    std_addr_d = map_addr;
                    std_dest_w_d = !instr_word[esx_pkg::DEST_BIT];
                    std_idx_d = map_indexed;
                    if (dec_move) begin
                        // no read strobe toward an indirect register, zero instead
                        mem_d.rd_en = !is_indirect(src_addr);
                        mem_d.rd_addr = src_addr;
                        src_zero_d = is_indirect(src_addr);
                        mv_indexed_d = instr_word[esx_pkg::MODE_BIT];
                        st_d = esx_pkg::ST_MOVE2;
                    end else if (dec_push) begin
                        mem_d.wr_en = 1'b1;
                        mem_d.wr_addr = ssp;
                        mem_d.wr_data = instr_word[esx_pkg::BYTE_W-1:0];
                        ptr_d[esx_pkg::SSP_IDX] = ssp - esx_pkg::SSP_STEP;
                    end else if (dec_sub) begin
                        if (sub_sel == esx_pkg::SEL_RETURN) begin
                            ptr_d[esx_pkg::SSP_IDX] = ssp - subk_ext;
                            flow_d.pop = 1'b1;
                            flow_d.pc_load = 1'b1;
                            flow_d.pc_value = return_stack_top;
                            st_d = esx_pkg::ST_FLUSH;
                        end else begin
                            ptr_d[sub_sel] = ptr_q[sub_sel] - subk_ext;
                        end
                    end else if (dec_call_via_working_reg) begin
                        flow_d.push = 1'b1;
                        flow_d.push_value = pc_now + esx_pkg::RET_STEP;
                        flow_d.pc_load = 1'b1;
                        flow_d.pc_value = {pc_latch_upper, pc_latch_high, working_register};
                        st_d = esx_pkg::ST_FLUSH;
                    end
                end
            end
            esx_pkg::ST_MOVE2: begin
                if (instr_valid) begin
                    st_d = esx_pkg::ST_DECODE;
                    // a malformed second word drops the move rather than writing
                    if (dec_second) begin
                        if (mv_indexed_q) begin
                            mem_d.wr_en = !is_indirect(dst_idx_addr);
                            mem_d.wr_addr = dst_idx_addr;
                        end else begin
                            mem_d.wr_en = 1'b1;
                            mem_d.wr_addr = instr_word[esx_pkg::DADDR_W-1:0];
                        end
                        mem_d.wr_data = src_zero_q ? esx_pkg::ZERO_BYTE : mem_rd_data;
                    end
                end
            end
            esx_pkg::ST_FLUSH: begin
                // the word fetched here is discarded
                if (instr_valid) begin
                    st_d = esx_pkg::ST_DECODE;
                end
            end
            default: begin
                st_d = esx_pkg::ST_DECODE;
            end
        endcase
        busy_d = (st_d != esx_pkg::ST_DECODE);
    end

    // ============================================================
    // registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_q <= esx_pkg::ST_DECODE;
            mem_q <= '0;
            flow_q <= '0;
            ptr_q <= {esx_pkg::NPTR{esx_pkg::PTR_RST}};
            mv_indexed_q <= 1'b0;
            src_zero_q <= 1'b0;
            std_addr_q <= '0;
            std_dest_w_q <= 1'b0;
            std_idx_q <= 1'b0;
            busy_q <= 1'b0;
        end else if (clk_en) begin
            st_q <= st_d;
            mem_q <= mem_d;
            flow_q <= flow_d;
            ptr_q <= ptr_d;
            mv_indexed_q <= mv_indexed_d;
            src_zero_q <= src_zero_d;
            std_addr_q <= std_addr_d;
            std_dest_w_q <= std_dest_w_d;
            std_idx_q <= std_idx_d;
            busy_q <= busy_d;
        end
    end

    // outputs straight from the registers
    assign mem_req = mem_q;
    assign flow_req = flow_q;
    assign ptr_out = ptr_q;
    assign std_operand_addr = std_addr_q;
    assign std_dest_to_w = std_dest_w_q;
    assign std_indexed = std_idx_q;
    assign busy = busy_q;

    // ============================================================
    // assertions
    default clocking dc @(posedge sys_clk iff clk_en);
    endclocking
    default disable iff (srst);

    logic go;
    assign go = (st_q == esx_pkg::ST_DECODE) && instr_valid;

    sequence s_sub_ret;
        go && dec_sub && sub_sel == esx_pkg::SEL_RETURN;
    endsequence

    sequence s_ret_then_idle;
        (flow_q.pop && flow_q.pc_load && st_q == esx_pkg::ST_FLUSH) ##1 (!mem_q.wr_en && !flow_q.pop);
    endsequence

    property p_move_src;
        go && dec_move |=> st_q == esx_pkg::ST_MOVE2
            && mem_q.rd_addr == $past(ssp) + esx_pkg::DADDR_W'($past(instr_word[esx_pkg::OFS_W-1:0]));
    endproperty
    a_move_src: assert property (p_move_src) else $error("move source address wrong");

    property p_file_dest;
        st_q == esx_pkg::ST_MOVE2 && instr_valid && dec_second && !mv_indexed_q
            |=> mem_q.wr_en && mem_q.wr_addr == $past(instr_word[esx_pkg::DADDR_W-1:0])
            && st_q == esx_pkg::ST_DECODE;
    endproperty
    a_file_dest: assert property (p_file_dest) else $error("file destination wrong");

    property p_src_zero;
        go && dec_move && is_indirect(src_addr) |=> !mem_q.rd_en ##1 (!mem_q.wr_en || mem_q.wr_data == '0);
    endproperty
    a_src_zero: assert property (p_src_zero) else $error("indirect source not zero");

    property p_dest_nop;
        st_q == esx_pkg::ST_MOVE2 && instr_valid && mv_indexed_q && is_indirect(dst_idx_addr)
            |=> !mem_q.wr_en;
    endproperty
    a_dest_nop: assert property (p_dest_nop) else $error("indirect destination written");

    property p_push;
        go && dec_push |=> mem_q.wr_en && mem_q.wr_addr == $past(ssp)
            && mem_q.wr_data == $past(instr_word[esx_pkg::BYTE_W-1:0])
            && ssp == $past(ssp) - esx_pkg::SSP_STEP && st_q == esx_pkg::ST_DECODE;
    endproperty
    a_push: assert property (p_push) else $error("push literal wrong");

    property p_sub;
        go && dec_sub && sub_sel != esx_pkg::SEL_RETURN |=> st_q == esx_pkg::ST_DECODE
            && ptr_q[$past(sub_sel)] == $past(ptr_q[sub_sel]) - $past(subk_ext);
    endproperty
    a_sub: assert property (p_sub) else $error("pointer subtract wrong");

    property p_sub_ret;
        s_sub_ret |=> s_ret_then_idle;
    endproperty
    a_sub_ret: assert property (p_sub_ret) else $error("subtract and return sequence wrong");

    property p_ret_target;
        s_sub_ret |=> flow_q.pc_value == $past(return_stack_top) && ssp == $past(ssp) - $past(subk_ext);
    endproperty
    a_ret_target: assert property (p_ret_target) else $error("return target wrong");

    property p_legacy_map;
        go && !extended_set_enable && instr_word[esx_pkg::ACC_BIT]
            |=> std_addr_q == {$past(bank_select_register), $past(instr_word[esx_pkg::BYTE_W-1:0])} && !std_idx_q;
    endproperty
    a_legacy_map: assert property (p_legacy_map) else $error("banked address wrong");

    property p_zero_ssp;
        go && !instr_word[esx_pkg::ACC_BIT] && instr_word[esx_pkg::BYTE_W-1:0] <= esx_pkg::ILO_LIMIT && ssp == '0
            |=> std_addr_q == {esx_pkg::ACC_LO_BANK, $past(instr_word[esx_pkg::BYTE_W-1:0])};
    endproperty
    a_zero_ssp: assert property (p_zero_ssp) else $error("zero pointer mapping differs");

    property p_indexed_map;
        go && extended_set_enable && !instr_word[esx_pkg::ACC_BIT]
            && instr_word[esx_pkg::BYTE_W-1:0] <= esx_pkg::ILO_LIMIT
            |=> std_idx_q && std_addr_q == $past(ssp) + esx_pkg::DADDR_W'($past(instr_word[esx_pkg::BYTE_W-1:0]))
            && std_dest_to_w == !$past(instr_word[esx_pkg::DEST_BIT]);
    endproperty
    a_indexed_map: assert property (p_indexed_map) else $error("indexed operand wrong");

    property p_gate;
        go && !extended_set_enable |=> !mem_q.wr_en && !flow_q.pc_load && st_q == esx_pkg::ST_DECODE;
    endproperty
    a_gate: assert property (p_gate) else $error("extended opcode ran while disabled");

    property p_call_via_working_reg;
        go && dec_call_via_working_reg |=> flow_q.push && flow_q.push_value == $past(pc_now) + esx_pkg::RET_STEP
            && flow_q.pc_value == {$past(pc_latch_upper), $past(pc_latch_high), $past(working_register)}
            ##1 !flow_q.push && ((st_q == esx_pkg::ST_DECODE) == $past(instr_valid));
    endproperty
    a_call_via_working_reg: assert property (p_call_via_working_reg) else $error("call via working register wrong");

endmodule // esx_core

/* core/esx_pkg.sv */
// ============================================================
// shared constants and carriers for the extended-set decoder
package esx_pkg;

    // ============================================================
    // widths
    localparam int DADDR_W = 12;
    localparam int PC_W = 21;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int OFS_W = 7;
    localparam int SUBK_W = 6;
    localparam int SEL_W = 2;
    localparam int BANK_W = 4;
    localparam int PCU_W = PC_W - 2 * BYTE_W;
    localparam int NPTR = 3;
    localparam int SSP_IDX = 2;

    // ============================================================
    // opcode prefixes in the top byte; word-two prefix is the top nibble, call is a whole word
    localparam int OPC_LSB = 8;
    localparam int SECOND_LSB = 12;
    localparam logic [7:0] OPC_MOVE_IDX = 8'heb;
    localparam logic [3:0] OPC_SECOND = 4'hf;
    localparam logic [7:0] OPC_PUSH_LIT = 8'hfa;
    localparam logic [7:0] OPC_SUB_PTR = 8'he9;
    localparam logic [15:0] OPC_CALL_W = 16'h0014;
    localparam logic [1:0] SEL_RETURN = 2'h3;

    // ============================================================
    // field positions
    localparam int MODE_BIT = 7;
    localparam int SEL_LSB = 6;
    localparam int ACC_BIT = 8;
    localparam int DEST_BIT = 9;

    // ============================================================
    // access bank and arithmetic constants
    localparam logic [7:0] ILO_LIMIT = 8'h5f;
    localparam logic [3:0] ACC_LO_BANK = 4'h0;
    localparam logic [3:0] ACC_HI_BANK = 4'hf;
    localparam logic [DADDR_W-1:0] SSP_STEP = 12'h001;
    localparam logic [PC_W-1:0] RET_STEP = 21'h000002;
    localparam logic [DADDR_W-1:0] PTR_RST = 12'h000;
    localparam logic [BYTE_W-1:0] ZERO_BYTE = 8'h00;

    // ============================================================
    // sequencer states
    typedef enum logic [2:0] {
        ST_DECODE = 3'b001,
        ST_MOVE2 = 3'b010,
        ST_FLUSH = 3'b100
    } esx_state_t;

    // data memory request
    typedef struct packed {
        logic rd_en;
        logic [DADDR_W-1:0] rd_addr;
        logic wr_en;
        logic [DADDR_W-1:0] wr_addr;
        logic [BYTE_W-1:0] wr_data;
    } esx_mem_req_t;

    // return stack and program counter request
    typedef struct packed {
        logic push;
        logic [PC_W-1:0] push_value;
        logic pop;
        logic pc_load;
        logic [PC_W-1:0] pc_value;
    } esx_flow_req_t;

endpackage

/* tb/esx_core_bench.sv */
`timescale 1ns/1ps
// ============================================================
// scenario bench for the extended-set decoder
module esx_core_bench;
    logic sys_clk, srst, clk_en, extended_set_enable, instr_valid, ptr_wr_en;
    logic [15:0] instr_word;
    logic [20:0] pc_now, return_stack_top;
    logic [7:0] working_register, pc_latch_high, mem_rd_data;
    logic [4:0] pc_latch_upper;
    logic [3:0] bank_select_register;
    logic [1:0] ptr_wr_sel;
    logic [11:0] ptr_wr_data;
    esx_pkg::esx_mem_req_t mem_req;
    esx_pkg::esx_flow_req_t flow_req;
    logic [2:0][11:0] ptr_out;
    logic [11:0] std_operand_addr;
    logic std_dest_to_w, std_indexed, busy;
    int num_errors = 0;
    int compares = 0;

    // indirect registers at fe0..fef so stack offsets can reach them
    esx_core #(.IND_LO(12'hfe0), .IND_HI(12'hfef)) esx_core_i (.sys_clk, .srst, .clk_en,
        .extended_set_enable, .instr_valid, .instr_word, .pc_now, .working_register, .pc_latch_high,
        .pc_latch_upper, .bank_select_register, .return_stack_top, .mem_rd_data, .ptr_wr_en,
        .ptr_wr_sel, .ptr_wr_data, .mem_req, .flow_req, .ptr_out, .std_operand_addr, .std_dest_to_w,
        .std_indexed, .busy);
    esx_mem_model esx_mem_model_i (.sys_clk, .mem_req, .mem_rd_data);

    // ============================================================
    // shared tasks; all driving happens at the falling edge
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", nm, exp, got);
            num_errors++;
        end
    endtask
    // word is taken at the next rising edge; returns where its answer is settled
    task automatic issue(input logic [15:0] w);
        instr_word = w;
        instr_valid = 1'h1;
        @(negedge sys_clk);
    endtask
    task automatic idle;
        instr_valid = 1'h0;
        @(negedge sys_clk);
    endtask
    task automatic set_ptr(input logic [1:0] s, input logic [11:0] v);
        ptr_wr_sel = s;
        ptr_wr_data = v;
        ptr_wr_en = 1'h1;
        @(negedge sys_clk);
        ptr_wr_en = 1'h0;
    endtask

    // ============================================================
    // scenarios
    task automatic t_push;
        set_ptr(2'h2, 12'h100);
        issue(16'hfaa5);
        chk("push wr_en", 1'h1, mem_req.wr_en);
        chk("push addr", 12'h100, mem_req.wr_addr);
        chk("push data", 8'ha5, mem_req.wr_data);
        chk("push ssp", 12'h0ff, ptr_out[2]);
        idle();
        set_ptr(2'h2, 12'h000);
        issue(16'hfa01);
        chk("wrap ssp", 12'hfff, ptr_out[2]);
        issue(16'hfa02);
        chk("b2b addr", 12'hfff, mem_req.wr_addr);
        chk("b2b ssp", 12'hffe, ptr_out[2]);
        idle();
    endtask
    // source offset 7f is the top of its range; destination far from the pointer
    task automatic t_move_file;
        set_ptr(2'h2, 12'h080);
        esx_mem_model_i.mem[12'h0ff] = 8'h33;
        issue(16'heb7f);
        chk("mvf rd_en", 1'h1, mem_req.rd_en);
        chk("mvf rd_addr", 12'h0ff, mem_req.rd_addr);
        chk("mvf busy", 1'h1, busy);
        issue(16'hfabc);
        chk("mvf wr_en", 1'h1, mem_req.wr_en);
        chk("mvf wr_addr", 12'habc, mem_req.wr_addr);
        chk("mvf data", 8'h33, mem_req.wr_data);
        chk("mvf busy end", 1'h0, busy);
        idle();
    endtask
    // the stack pointer is fd0 here; some don't-care bits of word two are set
    task automatic move_ss(input logic [6:0] zs, input logic [6:0] zd, input logic [7:0] d, input logic we);
        issue({8'heb, 1'h1, zs});
        issue({4'hf, 5'h15, zd});
        chk("mvs wr_en", we, mem_req.wr_en);
        if (we) begin
            chk("mvs wr_addr", 12'hfd0 + zd, mem_req.wr_addr);
            chk("mvs data", d, mem_req.wr_data);
        end
        idle();
    endtask
    task automatic t_sub;
        for (int f = 0; f < 3; f++) begin
            set_ptr(f[1:0], 12'h020);
            issue({8'he9, f[1:0], 6'h3f});
            chk("sub ptr", 12'hfe1, ptr_out[f]);
            idle();
        end
        set_ptr(2'h2, 12'h100);
        return_stack_top = 21'h012345;
        issue(16'he9c5);
        chk("ret ssp", 12'h0fb, ptr_out[2]);
        chk("ret pop", 1'h1, flow_req.pop);
        chk("ret load", 1'h1, flow_req.pc_load);
        chk("ret pc", 21'h012345, flow_req.pc_value);
        chk("ret busy", 1'h1, busy);
        issue(16'hfa77);
        chk("ret idle wr", 1'h0, mem_req.wr_en);
        chk("ret idle ssp", 12'h0fb, ptr_out[2]);
        idle();
    endtask
    task automatic t_call;
        pc_now = 21'h001004;
        issue(16'h0014);
        chk("call push", 1'h1, flow_req.push);
        chk("call ret", 21'h001006, flow_req.push_value);
        chk("call load", 1'h1, flow_req.pc_load);
        chk("call pc", 21'h011006, flow_req.pc_value);
        issue(16'h0000);
        chk("call idle", 1'h0, flow_req.push);
        idle();
    endtask
    // a low clock enable must hold every register, then the same word runs
    task automatic t_freeze;
        set_ptr(2'h2, 12'h100);
        clk_en = 1'h0;
        issue(16'hfa11);
        chk("frozen ssp", 12'h100, ptr_out[2]);
        chk("frozen wr", 1'h0, mem_req.wr_en);
        clk_en = 1'h1;
        issue(16'hfa11);
        chk("thawed ssp", 12'h0ff, ptr_out[2]);
        idle();
    endtask
    task automatic std(input logic en, input logic [15:0] w, input logic [11:0] a, input logic ix);
        extended_set_enable = en;
        issue(w);
        chk("std addr", a, std_operand_addr);
        chk("std indexed", ix, std_indexed);
        chk("std dest", !w[9], std_dest_to_w);
        idle();
    endtask

    // ============================================================
    // closing report and hang guard
    task automatic end_of_test;
        if (num_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        end_of_test();
    end
    initial begin
        sys_clk = 1'h0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // ============================================================
    // main sequence; software never targets program counter or stack-top bytes
    initial begin
        {srst, clk_en, extended_set_enable, instr_valid, ptr_wr_en} = 5'h1c;
        {instr_word, pc_now, return_stack_top, ptr_wr_sel, ptr_wr_data} = '0;
        {working_register, pc_latch_high, pc_latch_upper, bank_select_register} = {8'h06, 8'h10, 5'h01, 4'h3};
        repeat (20) @(negedge sys_clk);
        srst = 1'h0;
        chk("rst busy", 1'h0, busy);
        chk("rst ssp", 12'h000, ptr_out[2]);
        chk("rst wr", 1'h0, mem_req.wr_en);
        t_push();
        t_freeze();
        t_move_file();
        set_ptr(2'h2, 12'hfd0);
        esx_mem_model_i.mem[12'hfd5] = 8'h44;
        move_ss(7'h05, 7'h06, 8'h44, 1'h1);
        move_ss(7'h10, 7'h06, 8'h00, 1'h1);
        move_ss(7'h05, 7'h1f, 8'h00, 1'h0);
        t_sub();
        t_call();
        set_ptr(2'h2, 12'h200);
        std(1'h0, 16'h2450, 12'h050, 1'h0);
        std(1'h0, 16'h2580, 12'h380, 1'h0);
        std(1'h0, 16'h2480, 12'hf80, 1'h0);
        std(1'h1, 16'h2650, 12'h250, 1'h1);
        std(1'h1, 16'h245f, 12'h25f, 1'h1);
        std(1'h1, 16'h2460, 12'hf60, 1'h0);
        std(1'h1, 16'h2550, 12'h350, 1'h0);
        std(1'h0, 16'hfa55, 12'h055, 1'h0);
        chk("off push", 12'h200, ptr_out[2]);
        set_ptr(2'h2, 12'h000);
        std(1'h1, 16'h2450, 12'h050, 1'h1);
        end_of_test();
    end
endmodule // esx_core_bench

/* tb/esx_mem_model.sv */
`timescale 1ns/1ps
// ============================================================
// data memory on the far side of the decoder
module esx_mem_model (
    input wire logic sys_clk,
    input wire esx_pkg::esx_mem_req_t mem_req,
    output logic [esx_pkg::BYTE_W-1:0] mem_rd_data
);
    logic [7:0] mem [4096];
    logic [7:0] held_q = 8'h5a;
    logic rd_q = 1'h0;
    // writes land on the strobe edge; read data scrambles once its hold cycle is over
    always @(posedge sys_clk) begin
        if (mem_req.wr_en) mem[mem_req.wr_addr] <= mem_req.wr_data;
        rd_q <= mem_req.rd_en;
        if (mem_req.rd_en) held_q <= mem[mem_req.rd_addr];
        else if (!rd_q) held_q <= ~held_q;
    end
    // data shows in the strobe cycle and the two after
    always_comb begin
        if (mem_req.rd_en) mem_rd_data = mem[mem_req.rd_addr];
        else mem_rd_data = held_q;
    end
endmodule // esx_mem_model
